// File: design/tca_conv_ctrl.sv
// Conversion sequencer, timing and data ready control for the touch ADC
`timescale 1ns/1ps
module tca_conv_ctrl
	import tca_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_DIV,   // System clocks per conversion clock
	parameter int FCD2_COUNT  = FCD2_TICKS, // Delay code 10 in conversion clocks
	parameter int FCD3_COUNT  = FCD3_TICKS, // Delay code 11
	parameter int TMR2_COUNT  = TMR2_TICKS, // Repeat code 10
	parameter int TMR3_COUNT  = TMR3_TICKS  // Repeat code 11
)
(
	input  wire logic        CLOCK_I,        // System clock
	input  wire logic        RST_I,          // Synchronous reset
	input  wire logic        REG_WR_I,       // Register write strobe
	input  wire logic        REG_RD_I,       // Register read strobe
	input  wire tca_reg_t    REG_SEL_I,      // Register select
	input  wire logic [11:0] REG_WDATA_I,    // Write data
	output logic      [11:0] REG_RDATA_O,    // Read data
	input  wire logic        MODE_WR_I,      // Conversion mode write strobe
	input  wire logic [1:0]  MODE_I,         // Conversion mode value
	input  wire logic        RES_RD_I,       // Result register read strobe
	input  wire logic [3:0]  RES_IDX_I,      // Result channel index
	output logic      [11:0] RES_DATA_O,     // Result read data
	input  wire logic [11:0] ADC_DATA_I,     // Converter output word
	input  wire logic        STOP_ACQ_I,     // Acquisition inhibit pin
	input  wire logic        TOUCH_I,        // Screen touched, high active
	output logic             DATA_READY_N_O, // New data available, low active
	output logic             ADC_PWR_O,      // Converter powered
	output logic             REF_PWR_O,      // Internal reference powered
	output logic             VREF_OE_O,      // Reference pin driven
	output logic             SAMPLE_O,       // Acquisition running
	output logic      [3:0]  CHANNEL_O       // Channel being converted
);
	typedef enum logic [2:0] {ST_IDLE, ST_WAIT_TOUCH, ST_PRE, ST_ACQ, ST_CONV, ST_POST, ST_TIMER} tca_state_t;

	tca_state_t  state;
	tca_ctl_t    ctl;
	logic [11:0] seq0;
	logic [11:0] seq1;
	logic [11:0] res [NUM_CH];
	logic        inh_s1, inh_s2, touch_s1, touch_s2;
	logic        touch_d;
	logic [15:0] tick_cnt;
	logic        tick;
	logic [14:0] cnt;
	logic [10:0] mask;
	logic [3:0]  ch;
	logic [4:0]  avg_i;
	logic [15:0] acc;
	logic [15:0] sum;
	logic        master;
	logic        inhibit;
	logic        touched;
	logic        start;
	logic        start_master;
	logic [10:0] start_mask;
	logic [3:0]  nxt;
	logic        conv_end;
	logic        last_avg;
	logic        seq_done;
	logic        timer_end;
	logic        restart;
	logic        busy;

	// Channel k sits at register bit 11-k, bit 0 unused
	function automatic logic [10:0] ch_mask(input logic [11:0] r);
		logic [10:0] m;
		m = '0;
		for (int k = 0; k < NUM_CH; k++)
			m[k] = r[11 - k];
		return m;
	endfunction

	// Lowest selected channel at or above a start index
	function automatic logic [3:0] next_ch(input logic [10:0] m, input logic [4:0] from);
		logic [3:0] r;
		r = NO_CH;
		for (int k = NUM_CH - 1; k >= 0; k--)
			if (m[k] && 5'(k) >= from)
				r = 4'(k);
		return r;
	endfunction

	function automatic logic [14:0] fcd_ticks(input logic [1:0] c);
		case (c)
			2'h0:    fcd_ticks = 15'(FCD0_TICKS);
			2'h1:    fcd_ticks = 15'(FCD1_TICKS);
			2'h2:    fcd_ticks = 15'(FCD2_COUNT);
			default: fcd_ticks = 15'(FCD3_COUNT);
		endcase
	endfunction

	function automatic logic [14:0] tmr_ticks(input logic [1:0] c);
		case (c)
			2'h1:    tmr_ticks = 15'(TMR1_TICKS);
			2'h2:    tmr_ticks = 15'(TMR2_COUNT);
			default: tmr_ticks = 15'(TMR3_COUNT);
		endcase
	endfunction

	function automatic logic [4:0] avg_total(input logic [1:0] c);
		case (c)
			2'h0:    avg_total = 5'h01;
			2'h1:    avg_total = 5'h04;
			2'h2:    avg_total = 5'h08;
			default: avg_total = 5'h10;
		endcase
	endfunction

	function automatic logic [2:0] avg_shift(input logic [1:0] c);
		case (c)
			2'h0:    avg_shift = 3'h0;
			2'h1:    avg_shift = 3'h2;
			2'h2:    avg_shift = 3'h3;
			default: avg_shift = 3'h4;
		endcase
	endfunction

	// Pin synchronisers
	always_ff @(posedge CLOCK_I)
	begin
		inh_s1   <= STOP_ACQ_I;
		inh_s2   <= inh_s1;
		touch_s1 <= TOUCH_I;
		touch_s2 <= touch_s1;
		touch_d  <= touch_s2; // Previous touch level, for a new press
	end

	// Conversion clock tick
	always_ff @(posedge CLOCK_I)
	begin
		if (RST_I || tick)
			tick_cnt <= 16'h0000;
		else
			tick_cnt <= tick_cnt + 16'h0001;
	end
	assign tick = (tick_cnt == 16'(TICK_CYCLES - 1));

	// Event decode
	assign inhibit      = ctl.inhibit_level_select ? inh_s2 : !inh_s2;             // see (R2)
	assign touched      = touch_s2;
	assign start_master = MODE_WR_I && MODE_I == MODE_MASTER;
	assign start        = ctl.pm != PM_OFF && ((MODE_WR_I && MODE_I == MODE_SLAVE) // see (R6) (R19)
	                      || (state == ST_WAIT_TOUCH && touched && !touch_d) || restart); // see (R19)
	assign start_mask   = (start_master || (master && !MODE_WR_I)) ? ch_mask(seq1) : ch_mask(seq0); // see (R12) (R13)
	assign conv_end     = state == ST_CONV && tick && cnt == 15'h0000;
	assign last_avg     = avg_i == avg_total(ctl.averaging_count) - 5'h01;
	assign sum          = acc + 16'(ADC_DATA_I);
	assign nxt          = next_ch(mask, 5'(ch) + 5'h01);
	assign seq_done     = state == ST_POST && tick && cnt == 15'h0000;
	assign timer_end    = state == ST_TIMER && tick && cnt == 15'h0000;
	assign restart      = timer_end && !(master && !touched);
	assign busy         = state inside {ST_PRE, ST_ACQ, ST_CONV, ST_POST};

	// Register writes
	always_ff @(posedge CLOCK_I)
	begin
		if (RST_I)
		begin
			ctl  <= tca_ctl_t'(CTL2_RESET);
			seq0 <= SEQ_RESET;
			seq1 <= SEQ_RESET;
		end
		else if (REG_WR_I)
		begin
			if (REG_SEL_I == REG_CTL2)
				ctl <= tca_ctl_t'(REG_WDATA_I);
			else if (REG_SEL_I == REG_SEQ0)
				seq0 <= REG_WDATA_I;
			else if (REG_SEL_I == REG_SEQ1)
				seq1 <= REG_WDATA_I;
		end
	end

	// Register and result read data
	always_ff @(posedge CLOCK_I)
	begin
		if (RST_I)
		begin
			REG_RDATA_O <= 12'h000;
			RES_DATA_O  <= 12'h000;
		end
		else
		begin
			if (REG_RD_I)
			begin
				if (REG_SEL_I == REG_CTL2)
					REG_RDATA_O <= 12'(ctl);
				else if (REG_SEL_I == REG_SEQ0)
					REG_RDATA_O <= seq0;
				else if (REG_SEL_I == REG_SEQ1)
					REG_RDATA_O <= seq1;
				else
					REG_RDATA_O <= 12'h000;
			end
			if (RES_RD_I)
				RES_DATA_O <= (RES_IDX_I < 4'(NUM_CH)) ? res[RES_IDX_I] : 12'h000;
		end
	end

	// Sequencer state machine
	always_ff @(posedge CLOCK_I)
	begin
		if (RST_I || ctl.pm == PM_OFF || (MODE_WR_I && MODE_I == MODE_IDLE)) // see (R6)
		begin
			state  <= ST_IDLE;
			master <= 1'b0;
			cnt    <= 15'h0000;
			ch     <= 4'h0;
			mask   <= 11'h000;
			avg_i  <= 5'h00;
			acc    <= 16'h0000;
		end
		else if (start_master)
		begin
			state  <= ST_WAIT_TOUCH;                                     // see (R19)
			master <= 1'b1;
		end
		else if (start)
		begin
			if (MODE_WR_I)
				master <= 1'b0;
			mask  <= start_mask;
			ch    <= next_ch(start_mask, 5'h00);
			avg_i <= 5'h00;
			acc   <= 16'h0000;
			state <= next_ch(start_mask, 5'h00) == NO_CH ? ST_POST : ST_PRE;
			cnt   <= fcd_ticks(ctl.fcd) - 15'h0001;                     // see (R3) (R7)
		end
		else
		begin
			case (state)
				ST_PRE:
					if (tick)
					begin
						if (cnt == 15'h0000)
						begin
							state <= ST_ACQ;
							cnt   <= 15'(ACQ_BASE << ctl.sample_time_select) - 15'h0001; // see (R10)
						end
						else
							cnt <= cnt - 15'h0001;                        // see (R5)
					end
				ST_ACQ:
					if (tick && !inhibit)                                 // see (R2)
					begin
						if (cnt == 15'h0000)
						begin
							state <= ST_CONV;
							cnt   <= CONV_TICKS - 15'h0001;
						end
						else
							cnt <= cnt - 15'h0001;
					end
				ST_CONV:
					if (tick && cnt != 15'h0000)
						cnt <= cnt - 15'h0001;
					else if (conv_end && !last_avg)
					begin
						acc   <= sum;                                       // see (R11)
						avg_i <= avg_i + 5'h01;
						state <= ST_ACQ;
						cnt   <= 15'(ACQ_BASE << ctl.sample_time_select) - 15'h0001;
					end
					else if (conv_end)
					begin
						acc   <= 16'h0000;
						avg_i <= 5'h00;
						ch    <= nxt;
						state <= nxt == NO_CH ? ST_POST : (nxt <= XY_LAST_CH ? ST_PRE : ST_ACQ); // see (R4)
						cnt   <= nxt <= XY_LAST_CH ? fcd_ticks(ctl.fcd) - 15'h0001
						         : 15'(ACQ_BASE << ctl.sample_time_select) - 15'h0001;
					end
				ST_POST:
					if (tick && cnt != 15'h0000)
						cnt <= cnt - 15'h0001;
					else if (seq_done)
					begin
						state <= ctl.tmr != TMR_ONCE ? ST_TIMER : (master ? ST_WAIT_TOUCH : ST_IDLE); // see (R20)
						cnt   <= tmr_ticks(ctl.tmr) - 15'h0001;
					end
				ST_TIMER:
					if (master && !touched)
						state <= ST_WAIT_TOUCH;
					else if (tick)
						cnt <= cnt - 15'h0001;
				default:
					state <= state;
			endcase
		end
	end

	// Result store, only the averaged value lands
	always_ff @(posedge CLOCK_I)
	begin
		if (RST_I)
		begin
			for (int k = 0; k < NUM_CH; k++)
				res[k] <= 12'h000;
		end
		else if (conv_end && last_avg)
			res[ch] <= 12'(sum >> avg_shift(ctl.averaging_count));                   // see (R11)
	end

	// Data ready: completion wins over a read in the same cycle
	always_ff @(posedge CLOCK_I)
	begin
		if (RST_I || start)
			DATA_READY_N_O <= 1'b1;                                       // see (R14) (R16)
		else if (seq_done)
			DATA_READY_N_O <= 1'b0;                                       // see (R14)
		else if (RES_RD_I && !DATA_READY_N_O)
			DATA_READY_N_O <= 1'b1;                                       // see (R15)
	end

	// Power and pin outputs
	always_ff @(posedge CLOCK_I)
	begin
		if (RST_I)
		begin
			ADC_PWR_O <= 1'b0;
			REF_PWR_O <= 1'b0;
			VREF_OE_O <= 1'b0;
			SAMPLE_O  <= 1'b0;
			CHANNEL_O <= 4'h0;
		end
		else
		begin
			ADC_PWR_O <= ctl.pm == PM_ON || (ctl.pm != PM_OFF && busy);  // see (R6) (R7) (R8)
			REF_PWR_O <= !ctl.ref_ext && (ctl.pm == PM_ON || ctl.pm == PM_ADC || (ctl.pm == PM_ALL && busy)); // see (R1)
			VREF_OE_O <= !ctl.ref_ext && (ctl.pm == PM_ON || ctl.pm == PM_ADC || (ctl.pm == PM_ALL && busy));
			SAMPLE_O  <= state == ST_ACQ && !inhibit;
			CHANNEL_O <= ch;
		end
	end

	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (RST_I);

	// Checks
	a_ref_ext_off:   assert property (ctl.ref_ext |=> !REF_PWR_O && !VREF_OE_O) else $error("ref on"); // see (R1)
	a_inhibit_stall: assert property (state == ST_ACQ && inhibit && !MODE_WR_I && ctl.pm != PM_OFF
	                 |=> state == ST_ACQ && cnt == $past(cnt)) else $error("stall"); // see (R2)
	a_pre_holds:     assert property (state == ST_PRE && cnt != 15'h0000 && !MODE_WR_I && ctl.pm != PM_OFF
	                 |=> state == ST_PRE) else $error("pre cut"); // see (R5)
	a_acq_len:       assert property (state == ST_PRE && tick && cnt == 15'h0000 && !MODE_WR_I && ctl.pm != PM_OFF
	                 |=> cnt == 15'(ACQ_BASE << ctl.sample_time_select) - 15'h0001) else $error("acq len"); // see (R10)
	a_pm_off:        assert property (ctl.pm == PM_OFF |=> !ADC_PWR_O ##1 state == ST_IDLE) else $error("pm off"); // see (R6)
	a_pm_idle_down:  assert property (state == ST_IDLE && ctl.pm == PM_ALL |=> !ADC_PWR_O && !REF_PWR_O)
	                 else $error("idle power"); // see (R7)
	a_pm_on:         assert property (ctl.pm == PM_ON && !ctl.ref_ext |=> ADC_PWR_O && REF_PWR_O)
	                 else $error("always on"); // see (R8)
	a_ready_busy:    assert property (state == ST_ACQ || state == ST_CONV |-> DATA_READY_N_O)
	                 else $error("ready busy"); // see (R14)
	a_read_clears:   assert property (RES_RD_I && !DATA_READY_N_O && !seq_done |=> DATA_READY_N_O)
	                 else $error("read clear"); // see (R15)
	a_timer_restart: assert property (restart && !MODE_WR_I |=> DATA_READY_N_O && state != ST_TIMER)
	                 else $error("restart"); // see (R16)
	c_seq_done:      cover property (seq_done ##1 !DATA_READY_N_O);
	c_inhibit:       cover property (state == ST_ACQ && inhibit && tick);
	c_restart:       cover property (restart);
	c_average:       cover property (conv_end && last_avg && ctl.averaging_count != 2'h0);
endmodule

// File: design/tca_pkg.sv
// Constants and types for the touch ADC conversion control block
// Contract
// (R1) Reference bit 1 powers internal reference down
// (R2) Inhibit level bit picks active pin level
// (R3) First conversion delay 1/256/2048/16384 clocks
// (R4) Delay also before X/Y and after sequence; after a sequence the code waits the acquisition time instead
// (R5) Inhibit ignored during first conversion delay
// (R6) Power policy 00 keeps ADC off always
// (R7) Policy 01 powers ADC and reference per conversion
// (R8) Policy 10 always on; 11 ADC only down
// (R9) Host uses 01 or 11 with master sequencer
// (R10) Acquisition time 4/8/16/32 clocks
// (R11) Average 1/4/8/16 conversions, store final only
// (R12) Slave uses first, master second sequencer register
// (R13) Bit 11 is channel 0, bit 0 unused
// (R14) Data ready high idle/converting, low when done
// (R15) Result read while low returns it high
// (R16) Timer restart returns data ready high
// (R17) Host reads results only while ready low
// (R18) Host finishes reads before timer expires
// (R19) Mode 10 starts slave, 11 master on touch
// (R20) Repeat interval none/1024/2048/16384 clocks
package tca_pkg;
	typedef struct packed
	{
		logic [1:0] averaging_count;     // Averaging count
		logic [1:0] sample_time_select;     // Sample time select
		logic [1:0] pm;      // Power policy
		logic [1:0] fcd;     // First conversion delay
		logic       inhibit_level_select;     // Inhibit level select
		logic       ref_ext; // External reference
		logic [1:0] tmr;     // Repeat interval
	} tca_ctl_t;

	typedef enum logic [1:0] {REG_CTL2, REG_SEQ0, REG_SEQ1, REG_NONE} tca_reg_t;

	localparam logic [11:0] CTL2_RESET  = 12'h000;
	localparam logic [11:0] SEQ_RESET   = 12'h000;
	localparam logic [1:0]  MODE_IDLE   = 2'h0;
	localparam logic [1:0]  MODE_SLAVE  = 2'h2;
	localparam logic [1:0]  MODE_MASTER = 2'h3;
	localparam logic [1:0]  PM_OFF      = 2'h0;
	localparam logic [1:0]  PM_ALL      = 2'h1;
	localparam logic [1:0]  PM_ON       = 2'h2;
	localparam logic [1:0]  PM_ADC      = 2'h3;
	localparam logic [1:0]  TMR_ONCE    = 2'h0;
	localparam int          NUM_CH      = 11;
	localparam logic [3:0]  XY_LAST_CH  = 4'h1;
	localparam logic [3:0]  NO_CH       = 4'hf;
	localparam int          CLK_NS      = 10;
	localparam int          CONV_CLK_NS = 500;
	localparam int          TICK_DIV    = CONV_CLK_NS / CLK_NS;
	localparam logic [14:0] CONV_TICKS  = 15'h000d;
	localparam logic [5:0]  ACQ_BASE    = 6'h04;
	localparam int          FCD0_TICKS  = 1;
	localparam int          FCD1_TICKS  = 256;
	localparam int          FCD2_TICKS  = 2048;
	localparam int          FCD3_TICKS  = 16384;
	localparam int          TMR1_TICKS  = 1024;
	localparam int          TMR2_TICKS  = 2048;
	localparam int          TMR3_TICKS  = 16384;
endpackage

// File: verification/tca_host_model.sv
// Host processor model driving the register, mode and result ports
`timescale 1ns/1ps
module tca_host_model
	import tca_pkg::*;
(
	input  wire logic   clock_i,   // System clock
	output logic        wr_o,      // Register write strobe
	output logic        rd_o,      // Register read strobe
	output tca_reg_t    sel_o,     // Register select
	output logic [11:0] wdata_o,   // Write data
	output logic        mode_wr_o, // Mode write strobe
	output logic [1:0]  mode_o,    // Mode value
	output logic        res_rd_o,  // Result read strobe
	output logic [3:0]  idx_o      // Result channel
);
	// Idle lines at time zero
	initial
	begin
		{wr_o, rd_o, mode_wr_o, res_rd_o} = 4'h0;
		sel_o = REG_NONE;
		wdata_o = 12'h000;
		mode_o = MODE_IDLE;
		idx_o = 4'h0;
	end
	// Register write; data scrambled once released
	task put(input tca_reg_t s, input logic [11:0] d);
		sel_o <= s;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clock_i);
		wr_o <= 1'b0;
		wdata_o <= ~d;
		@(posedge clock_i);
	endtask
	// Register read
	task get(input tca_reg_t s);
		sel_o <= s;
		rd_o <= 1'b1;
		@(posedge clock_i);
		rd_o <= 1'b0;
		sel_o <= REG_NONE;
		@(posedge clock_i);
	endtask
	// Mode write; master only after policy 01 or 11 is set
	task mode(input logic [1:0] m);
		mode_o <= m;
		mode_wr_o <= 1'b1;
		@(posedge clock_i);
		mode_wr_o <= 1'b0;
		mode_o <= ~m;
		@(posedge clock_i);
	endtask
	// Result read after 0 to 3 idle cycles, with no check of data ready or the timer
	task res(input logic [3:0] i);
		repeat ($urandom_range(0, 3)) @(posedge clock_i);
		idx_o <= i;
		res_rd_o <= 1'b1;
		@(posedge clock_i);
		res_rd_o <= 1'b0;
		idx_o <= ~i;
		@(posedge clock_i);
	endtask
endmodule

// File: verification/test_tca_conv_ctrl.sv
// Self-checking testbench for the touch ADC conversion control block
`timescale 1ns/1ps
module test_tca_conv_ctrl
	import tca_pkg::*;
;
	localparam int       FCD_T[4] = '{1, 256, 8, 16};
	localparam int       AVG_T[4] = '{1, 4, 8, 16};
	localparam logic [4:0] PW[6]  = '{5'b10011, 5'b10110, 5'b11001, 5'b11100, 5'b01000, 5'b00000};
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        reg_wr, reg_rd, mode_wr, res_rd, rdy_n, adc_pwr, ref_pwr, oe, smp;
	tca_reg_t    reg_sel;
	logic [11:0] wdata, rdata, rres;
	logic [11:0] adc = 12'h000;
	logic [1:0]  mode_v;
	logic [3:0]  res_idx, chan;
	logic        stop_acq = 1'b1;
	logic        touch = 1'b0;
	logic        reg_rd_d = 1'b0;
	logic        res_rd_d = 1'b0;
	logic [11:0] exp_q[$];
	int          n_errors = 0;
	int          samples_checked = 0;
	int          cyc = 0;
	int          rises = 0;

	always #5 clk = ~clk;

	tca_conv_ctrl #(.TICK_CYCLES(1), .FCD2_COUNT(8), .FCD3_COUNT(16), .TMR2_COUNT(8), .TMR3_COUNT(16)) u_tca_conv_ctrl (
		.CLOCK_I(clk), .RST_I(rst), .REG_WR_I(reg_wr), .REG_RD_I(reg_rd), .REG_SEL_I(reg_sel),
		.REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .MODE_WR_I(mode_wr), .MODE_I(mode_v), .RES_RD_I(res_rd),
		.RES_IDX_I(res_idx), .RES_DATA_O(rres), .ADC_DATA_I(adc), .STOP_ACQ_I(stop_acq), .TOUCH_I(touch),
		.DATA_READY_N_O(rdy_n), .ADC_PWR_O(adc_pwr), .REF_PWR_O(ref_pwr), .VREF_OE_O(oe), .SAMPLE_O(smp),
		.CHANNEL_O(chan));
	tca_host_model u_tca_host_model (.clock_i(clk), .wr_o(reg_wr), .rd_o(reg_rd), .sel_o(reg_sel),
		.wdata_o(wdata), .mode_wr_o(mode_wr), .mode_o(mode_v), .res_rd_o(res_rd), .idx_o(res_idx));

	task automatic chk_w(input string nm, input logic [11:0] e, input logic [11:0] s);
		samples_checked++;
		if (s !== e)
		begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic chk_b(input string nm, input logic e, input logic s);
		chk_w(nm, {11'h000, e}, {11'h000, s});
	endtask
	task automatic chk_n(input string nm, input int e, input int s);
		samples_checked++;
		if (s != e)
		begin
			n_errors++;
			$display("MISMATCH %s expected %0d seen %0d", nm, e, s);
		end
	endtask
	// Reads note the expected word; the monitor compares it
	task automatic rd_reg(input tca_reg_t s, input logic [11:0] e);
		exp_q.push_back(e);
		u_tca_host_model.get(s);
	endtask
	task automatic rd_res(input logic [3:0] i, input logic [11:0] e);
		exp_q.push_back(e);
		u_tca_host_model.res(i);
	endtask
	task automatic wait_rdy(output int n);
		n = 0;
		while (rdy_n !== 1'b0 && n < 5000)
		begin
			@(posedge clk);
			n++;
		end
		chk_b("data_ready_n done", 1'b0, rdy_n);
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Read data lands the cycle after its strobe
	always @(posedge clk)
	begin
		reg_rd_d <= reg_rd;
		res_rd_d <= res_rd;
	end
	always @(negedge clk)
		if (reg_rd_d || res_rd_d)
			chk_w(reg_rd_d ? "reg_rdata" : "res_data", exp_q.pop_front(), reg_rd_d ? rdata : rres);
	// Acquisition count and run limit
	always @(posedge smp)
		rises++;
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_errors++;
			wrap_up();
		end
	end

	initial
	begin
		int i, n0, n, w;
		logic [11:0] d, s0, s1, c;
		void'($urandom(32'h49da6e44));
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		// Reset values, random write and readback, unmapped select
		rd_reg(REG_CTL2, CTL2_RESET);
		rd_reg(REG_SEQ0, SEQ_RESET);
		chk_b("data_ready_n idle", 1'b1, rdy_n);
		s0 = 12'($urandom) & 12'hffe;
		s1 = 12'($urandom) & 12'hffe;
		c = 12'($urandom) & 12'hf3f;
		u_tca_host_model.put(REG_SEQ0, s0);
		u_tca_host_model.put(REG_SEQ1, s1);
		u_tca_host_model.put(REG_CTL2, c);
		u_tca_host_model.put(REG_NONE, 12'hfff);
		rd_reg(REG_SEQ0, s0);
		rd_reg(REG_SEQ1, s1);
		rd_reg(REG_CTL2, c);
		rd_reg(REG_NONE, 12'h000);
		// Policy 00 blocks a slave start
		rises = 0;
		u_tca_host_model.mode(MODE_SLAVE);
		repeat (40) @(posedge clk);
		chk_b("adc power off", 1'b0, adc_pwr);
		chk_n("no acquisition", 0, rises);
		// Power outputs per policy and reference select
		for (i = 0; i < 6; i++)
		begin
			u_tca_host_model.put(REG_CTL2, {4'h0, PW[i][4:3], 3'h0, PW[i][2], 2'h0});
			repeat (4) @(posedge clk);
			chk_b("adc power", PW[i][1], adc_pwr);
			chk_b("ref power", PW[i][0], ref_pwr);
			if (PW[i][4:3] == PM_ON)
				chk_b("vref drive", ~PW[i][2], oe);
		end
		// Delay, acquisition and averaging codes on channel 3 only
		u_tca_host_model.put(REG_SEQ0, 12'h100);
		u_tca_host_model.put(REG_SEQ1, 12'h040);
		for (i = 0; i < 4; i++)
		begin
			d = 12'($urandom);
			adc <= d;
			u_tca_host_model.put(REG_CTL2, {i[1:0], i[1:0], PM_ALL, i[1:0], 4'h0});
			rises = 0;
			u_tca_host_model.mode(MODE_SLAVE);
			n = 0;
			while (smp !== 1'b1 && n < 400)
			begin
				@(posedge clk);
				n++;
			end
			w = 0;
			while (smp === 1'b1 && w < 100)
			begin
				@(posedge clk);
				w++;
			end
			if (i == 0)
				n0 = n;
			chk_n("first delay", FCD_T[i] - FCD_T[0], n - n0);
			chk_n("sample width", 4 << i, w);
			chk_b("data_ready_n busy", 1'b1, rdy_n);
			wait_rdy(n);
			chk_n("conversions", AVG_T[i], rises);
			rd_res(4'h3, d);
			chk_b("ready after read", 1'b1, rdy_n);
			chk_b("adc power idle", 1'b0, adc_pwr);
		end
		rd_res(4'h5, 12'h000);
		// Inhibit pin for both level settings
		for (i = 0; i < 2; i++)
		begin
			u_tca_host_model.put(REG_CTL2, {4'h0, PM_ALL, 2'h0, i[0], 3'h0});
			stop_acq <= i[0];
			rises = 0;
			u_tca_host_model.mode(MODE_SLAVE);
			repeat (60) @(posedge clk);
			chk_n("inhibited", 0, rises);
			stop_acq <= ~i[0];
			wait_rdy(n);
			rd_res(4'h3, d);
		end
		stop_acq <= 1'b1;
		// Repeat timer restarts and clears data ready
		d = 12'($urandom);
		adc <= d;
		u_tca_host_model.put(REG_CTL2, {4'h0, PM_ALL, 4'h0, 2'h1});
		u_tca_host_model.mode(MODE_SLAVE);
		wait_rdy(n);
		rd_res(4'h3, d);
		wait_rdy(n);
		n = 0;
		while (rdy_n === 1'b0 && n < 2000)
		begin
			@(posedge clk);
			n++;
		end
		chk_b("timer restart", 1'b1, n >= 1020 && n <= 1030);
		u_tca_host_model.mode(MODE_IDLE);
		// Master mode waits for touch and uses the second mask
		repeat (40) @(posedge clk);
		u_tca_host_model.put(REG_CTL2, {4'h0, PM_ADC, 6'h00});
		s0 = d;
		d = 12'($urandom);
		adc <= d;
		rises = 0;
		u_tca_host_model.mode(MODE_MASTER);
		repeat (40) @(posedge clk);
		chk_n("no touch", 0, rises);
		touch <= 1'b1;
		wait_rdy(n);
		rd_res(4'h5, d);
		rd_res(4'h3, s0);
		touch <= 1'b0;
		u_tca_host_model.mode(MODE_IDLE);
		wrap_up();
	end
endmodule
